// *** pkg/crt_defines.svh ***
`ifndef CRT_DEFINES_SVH
`define CRT_DEFINES_SVH

// ============================================================
// Register indices behind the data port
`define CRT_IDX_HTOTAL 8'h00
`define CRT_IDX_HDEND 8'h01
`define CRT_IDX_HBSTART 8'h02
`define CRT_IDX_HBEND 8'h03
`define CRT_IDX_HSSTART 8'h04
`define CRT_IDX_HSEND 8'h05
`define CRT_IDX_VTOTAL 8'h06
`define CRT_IDX_VHIGH 8'h07
`define CRT_IDX_HEXT 8'h5d
`define CRT_IDX_VEXT 8'h5e

// ============================================================
// I/O port addresses (index port; data port is the next byte)
`define CRT_IO_MONO 16'h03b4
`define CRT_IO_COLOR 16'h03d4
`define CRT_IO_DATA_OFS 16'h0001

// ============================================================
// Reset values
`define CRT_RST_INDEX 8'h00
`define CRT_RST_REG 8'h00
`define CRT_RST_READ 16'h0000

// ============================================================
// Field positions
`define CRT_HEXT_HT8 0
`define CRT_HEXT_HDE8 1
`define CRT_HEXT_HBS8 2
`define CRT_HEXT_HBE6 3
`define CRT_HEXT_HSS8 4
`define CRT_HEXT_HSE5 5
`define CRT_HEXT_STRETCH 6
`define CRT_HBE_SKEW_HI 6
`define CRT_HBE_SKEW_LO 5
`define CRT_HSE_SKEW_HI 6
`define CRT_HSE_SKEW_LO 5
`define CRT_HSE_HBE5 7
`define CRT_VH_VT8 0
`define CRT_VH_VT9 5
`define CRT_VEXT_VT10 0
`define CRT_HBE_LOW_MSB 4
`define CRT_HSE_LOW_MSB 4
`define CRT_HBE_CMP_MSB 6
`define CRT_HSE_CMP_MSB 5

// ============================================================
// Timing constants
`define CRT_HT_ADJ 9'h004
`define CRT_STRETCH_DOTS 6'h20

`endif

// *** pkg/crt_pkg.sv ***
package crt_pkg;
  `include "crt_defines.svh"

  // ============================================================
  // State of the timing block, apart from the taps held in the skew delay lines
  typedef struct packed {
    logic [7:0] index;
    logic [7:0] htotal;
    logic [7:0] hdend;
    logic [7:0] hbstart;
    logic [7:0] hbend;
    logic [7:0] hsstart;
    logic [7:0] hsend;
    logic [7:0] vtotal;
    logic [7:0] vhigh;
    logic [7:0] hext;
    logic [7:0] vext;
    logic [15:0] rdata;
    logic hit;
    logic [3:0] dot_cnt;
    logic [8:0] hcnt;
    logic [10:0] vcnt;
    logic blank;
    logic hs_raw;
    logic hs_skewed_prev;
    logic [5:0] stretch_cnt;
    logic hsync;
    logic blank_out;
    logic de_out;
  } crt_state_t;
endpackage

// *** pkg/crt_skew_if.sv ***
`timescale 1ns/1ps
// ============================================================
// Carrier between the timing core and one skew delay line
interface crt_skew_if;
  logic tick;
  logic din;
  logic [1:0] sel;
  logic dout;
  modport unit (input tick, input din, input sel, output dout);
  modport user (output tick, output din, output sel, input dout);
endinterface

// *** hdl/crt_skew.sv ***
`timescale 1ns/1ps
// ============================================================
// Delay of zero to three character clocks
module crt_skew
  import crt_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  crt_skew_if.unit sk
);
  typedef struct packed {
    logic [2:0] taps;
  } crt_skew_state_t;

  crt_skew_state_t st_reg;
  crt_skew_state_t st_next;

  // Shift only on character ticks so skew is in character units
  always_comb begin
    st_next = st_reg;
    if (sk.tick) begin
      st_next.taps = {st_reg.taps[1:0], sk.din};
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Zero skew passes the input straight through
  always_comb begin
    unique case (sk.sel)
      2'h0: sk.dout = sk.din;
      2'h1: sk.dout = st_reg.taps[0];
      2'h2: sk.dout = st_reg.taps[1];
      2'h3: sk.dout = st_reg.taps[2];
    endcase
  end

  // Each character tick moves the input into the first tap
  AST_SKEW_SHIFT: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    sk.tick |=> (st_reg.taps[0] == $past(sk.din)))
    else $error("skew line did not take its input");
endmodule

// *** hdl/crt_timing.sv ***
`timescale 1ns/1ps
module crt_timing
  import crt_pkg::*;
#(
  parameter int DOTS_PER_CHAR = 8
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic color_sel_i,
  input wire logic [15:0] io_addr_i,
  input wire logic io_wr_i,
  input wire logic io_rd_i,
  input wire logic [1:0] io_be_i,
  input wire logic [15:0] io_wdata_i,
  output logic [15:0] io_rdata_o,
  output logic io_hit_o,
  output logic hsync_o,
  output logic blank_o,
  output logic display_en_o
);
  localparam logic [3:0] DOT_LAST = 4'(DOTS_PER_CHAR - 1);

  crt_state_t st_reg;
  crt_state_t st_next;

  crt_skew_if de_sk ();
  crt_skew_if hs_sk ();

  // ============================================================
  // Skew delay lines
  crt_skew u_de_skew (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .sk(de_sk.unit)
  );

  crt_skew u_hs_skew (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .sk(hs_sk.unit)
  );

  // ============================================================
  // Assembled timing fields
  logic tick;
  logic [15:0] base;
  logic acc_idx;
  logic acc_dat;
  logic [8:0] ht9;
  logic [8:0] hde9;
  logic [8:0] hbs9;
  logic [6:0] hbe7;
  logic [8:0] hss9;
  logic [5:0] hse6;
  logic [10:0] vt11;
  logic de_raw;
  logic line_end;
  logic wr_en;
  logic [7:0] wr_idx;
  logic [7:0] wr_dat;
  logic [7:0] rd_idx;
  logic [7:0] rd_val;
  logic hs_after_skew;

  assign tick = (st_reg.dot_cnt == DOT_LAST);
  assign base = color_sel_i ? `CRT_IO_COLOR : `CRT_IO_MONO;
  assign acc_idx = (io_addr_i == base);
  assign acc_dat = (io_addr_i == (base + `CRT_IO_DATA_OFS));

  // High bits come from the extension and high-bits registers; blank end bit 5 comes from the sync end register
  assign ht9 = {st_reg.hext[`CRT_HEXT_HT8], st_reg.htotal};
  assign hde9 = {st_reg.hext[`CRT_HEXT_HDE8], st_reg.hdend};
  assign hbs9 = {st_reg.hext[`CRT_HEXT_HBS8], st_reg.hbstart};
  assign hbe7 = {st_reg.hext[`CRT_HEXT_HBE6], st_reg.hsend[`CRT_HSE_HBE5],
                 st_reg.hbend[`CRT_HBE_LOW_MSB:0]};
  assign hss9 = {st_reg.hext[`CRT_HEXT_HSS8], st_reg.hsstart};
  assign hse6 = {st_reg.hext[`CRT_HEXT_HSE5], st_reg.hsend[`CRT_HSE_LOW_MSB:0]};
  assign vt11 = {st_reg.vext[`CRT_VEXT_VT10], st_reg.vhigh[`CRT_VH_VT9],
                 st_reg.vhigh[`CRT_VH_VT8], st_reg.vtotal};

  // Line is htotal plus five characters, so the last count is htotal plus four
  assign line_end = (st_reg.hcnt == ht9 + `CRT_HT_ADJ);
  assign de_raw = (st_reg.hcnt <= hde9);

  // Skew selections straight from their register fields
  assign de_sk.tick = tick;
  assign de_sk.din = de_raw;
  assign de_sk.sel = st_reg.hbend[`CRT_HBE_SKEW_HI:`CRT_HBE_SKEW_LO];
  assign hs_sk.tick = tick;
  assign hs_sk.din = st_reg.hs_raw;
  assign hs_sk.sel = st_reg.hsend[`CRT_HSE_SKEW_HI:`CRT_HSE_SKEW_LO];
  assign hs_after_skew = hs_sk.dout;

  // ============================================================
  // Bus decode: a word at the index port carries index and data
  always_comb begin
    wr_en = 1'b0;
    wr_idx = st_reg.index;
    wr_dat = io_wdata_i[7:0];
    rd_idx = st_reg.index;
    if (io_wr_i && acc_idx && io_be_i[1]) begin
      wr_en = 1'b1;
      wr_idx = io_be_i[0] ? io_wdata_i[7:0] : st_reg.index;
      wr_dat = io_wdata_i[15:8];
    end else if (io_wr_i && acc_dat && io_be_i[0]) begin
      wr_en = 1'b1;
    end
  end

  // Read mux; unmapped indices read as zero
  always_comb begin
    unique case (rd_idx)
      `CRT_IDX_HTOTAL: rd_val = st_reg.htotal;
      `CRT_IDX_HDEND: rd_val = st_reg.hdend;
      `CRT_IDX_HBSTART: rd_val = st_reg.hbstart;
      `CRT_IDX_HBEND: rd_val = st_reg.hbend;
      `CRT_IDX_HSSTART: rd_val = st_reg.hsstart;
      `CRT_IDX_HSEND: rd_val = st_reg.hsend;
      `CRT_IDX_VTOTAL: rd_val = st_reg.vtotal;
      `CRT_IDX_VHIGH: rd_val = st_reg.vhigh;
      `CRT_IDX_HEXT: rd_val = st_reg.hext;
      `CRT_IDX_VEXT: rd_val = st_reg.vext;
      default: rd_val = `CRT_RST_REG;
    endcase
  end

  // ============================================================
  // Next state: registers, counters and raster outputs
  always_comb begin
    st_next = st_reg;
    st_next.hit = (io_wr_i || io_rd_i) && (acc_idx || acc_dat);
    // Index lane of the index port
    if (io_wr_i && acc_idx && io_be_i[0]) begin
      st_next.index = io_wdata_i[7:0];
    end
    // Indexed write, also reaching the two extension registers
    if (wr_en) begin
      unique case (wr_idx)
        `CRT_IDX_HTOTAL: st_next.htotal = wr_dat;
        `CRT_IDX_HDEND: st_next.hdend = wr_dat;
        `CRT_IDX_HBSTART: st_next.hbstart = wr_dat;
        `CRT_IDX_HBEND: st_next.hbend = wr_dat;
        `CRT_IDX_HSSTART: st_next.hsstart = wr_dat;
        `CRT_IDX_HSEND: st_next.hsend = wr_dat;
        `CRT_IDX_VTOTAL: st_next.vtotal = wr_dat;
        `CRT_IDX_VHIGH: st_next.vhigh = wr_dat;
        `CRT_IDX_HEXT: st_next.hext = wr_dat;
        `CRT_IDX_VEXT: st_next.vext = wr_dat;
        default: st_next.hit = st_next.hit; // Unmapped: write dropped
      endcase
    end
    // Read data: index in the low lane at the index port, data above it
    if (io_rd_i && acc_idx) begin
      st_next.rdata = {rd_val, st_reg.index};
    end else if (io_rd_i && acc_dat) begin
      st_next.rdata = {8'h00, rd_val};
    end
    // Dot counter gives one tick per character
    st_next.dot_cnt = tick ? 4'h0 : st_reg.dot_cnt + 4'h1;
    if (tick) begin
      if (line_end) begin
        st_next.hcnt = 9'h000;
        if (st_reg.vcnt == vt11) begin
          st_next.vcnt = 11'h000;
        end else begin
          st_next.vcnt = st_reg.vcnt + 11'h001;
        end
      end else begin
        st_next.hcnt = st_reg.hcnt + 9'h001;
      end
      // Start wins if start and end coincide
      if (st_reg.hcnt == hbs9) begin
        st_next.blank = 1'b1;
      end else if (st_reg.hcnt[`CRT_HBE_CMP_MSB:0] == hbe7) begin
        st_next.blank = 1'b0;
      end
      if (st_reg.hcnt == hss9) begin
        st_next.hs_raw = 1'b1;
      end else if (st_reg.hcnt[`CRT_HSE_CMP_MSB:0] == hse6) begin
        st_next.hs_raw = 1'b0;
      end
    end
    // Stretch counts dots after the skewed pulse falls, so it adds 32 dots
    st_next.hs_skewed_prev = hs_after_skew;
    if (st_reg.hs_skewed_prev && !hs_after_skew && st_reg.hext[`CRT_HEXT_STRETCH]) begin
      st_next.stretch_cnt = `CRT_STRETCH_DOTS;
    end else if (st_reg.stretch_cnt != 6'h00) begin
      st_next.stretch_cnt = st_reg.stretch_cnt - 6'h01;
    end
    st_next.hsync = hs_after_skew || (st_next.stretch_cnt != 6'h00);
    st_next.blank_out = st_reg.blank;
    st_next.de_out = de_sk.dout;
  end

  // Timing registers clear at reset too; zero is no useful raster mode
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      st_reg <= '0;
      st_reg.index <= `CRT_RST_INDEX;
      st_reg.rdata <= `CRT_RST_READ;
    end else begin
      st_reg <= st_next;
    end
  end

  // ============================================================
  // Outputs straight from the state register
  assign io_rdata_o = st_reg.rdata;
  assign io_hit_o = st_reg.hit;
  assign hsync_o = st_reg.hsync;
  assign blank_o = st_reg.blank_out;
  assign display_en_o = st_reg.de_out;

  // ============================================================
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  AST_DATA_ROUTE: assert property (
    (io_wr_i && acc_dat && io_be_i[0] && st_reg.index == `CRT_IDX_HTOTAL)
    |=> (st_reg.htotal == $past(io_wdata_i[7:0])))
    else $error("data port write missed indexed register");

  AST_DECODE_OTHER: assert property (
    ((io_wr_i || io_rd_i) && io_addr_i == (color_sel_i ? `CRT_IO_MONO : `CRT_IO_COLOR))
    |=> !io_hit_o)
    else $error("inactive port range answered");

  AST_WORD_WRITE: assert property (
    (io_wr_i && acc_idx && io_be_i == 2'h3 && io_wdata_i[7:0] == `CRT_IDX_VTOTAL)
    |=> (st_reg.index == `CRT_IDX_VTOTAL) && (st_reg.vtotal == $past(io_wdata_i[15:8])))
    else $error("word write did not load index and data");

  AST_INDEX_RESET: assert property (
    !$past(rst_b_i) |-> (st_reg.index == `CRT_RST_INDEX))
    else $error("index not zero after reset");

  AST_LINE_WRAP: assert property (
    (tick && line_end) |=> (st_reg.hcnt == 9'h000) && (st_reg.vcnt != $past(st_reg.vcnt)
      || $past(st_reg.vcnt) != $past(vt11) || st_reg.vcnt == 11'h000))
    else $error("character counter did not wrap at line end");

  AST_LINE_LEN: assert property (
    (tick && st_reg.hcnt != ht9 + `CRT_HT_ADJ)
    |=> (st_reg.hcnt == $past(st_reg.hcnt) + 9'h001))
    else $error("character counter did not advance");

  AST_FRAME_WRAP: assert property (
    (tick && line_end && st_reg.vcnt == vt11) |=> (st_reg.vcnt == 11'h000))
    else $error("line counter did not wrap at frame length");

  AST_BLANK_START: assert property (
    (tick && st_reg.hcnt == hbs9) |=> st_reg.blank ##1 blank_o)
    else $error("blank did not start at start value");

  AST_BLANK_END: assert property (
    (tick && st_reg.hcnt != hbs9 && st_reg.hcnt[`CRT_HBE_CMP_MSB:0] == hbe7) |=> !st_reg.blank)
    else $error("blank did not end at end value");

  AST_SYNC_START: assert property (
    (tick && st_reg.hcnt == hss9) |=> st_reg.hs_raw)
    else $error("sync did not start at start value");

  AST_SYNC_END: assert property (
    (tick && st_reg.hcnt != hss9 && st_reg.hcnt[`CRT_HSE_CMP_MSB:0] == hse6) |=> !st_reg.hs_raw)
    else $error("sync did not end at end value");

  AST_SYNC_NOSKEW: assert property (
    (hs_sk.sel == 2'h0 && st_next.stretch_cnt == 6'h00) |=> (hsync_o == $past(st_reg.hs_raw)))
    else $error("unskewed sync does not follow raw sync");

  AST_STRETCH: assert property (
    (st_reg.hs_skewed_prev && !hs_after_skew && st_reg.hext[`CRT_HEXT_STRETCH])
    |=> hsync_o [*8])
    else $error("sync not stretched after its end");

  AST_DE_NOSKEW: assert property (
    (de_sk.sel == 2'h0) |=> (display_en_o == $past(de_raw)))
    else $error("unskewed display enable wrong");

  // Bus answers, counter steps and raster levels between ticks
  AST_HIT_DATA: assert property (
    ((io_wr_i || io_rd_i) && acc_dat)
    |=> io_hit_o)
    else $error("data port access gave no hit");

  AST_DATA_READ: assert property (
    (io_rd_i && acc_dat && st_reg.index == `CRT_IDX_HEXT)
    |=> (io_rdata_o == {8'h00, $past(st_reg.hext)}))
    else $error("extension register not read through data port");

  AST_READ_INDEX: assert property (
    (io_rd_i && acc_idx)
    |=> (io_rdata_o[7:0] == $past(st_reg.index)))
    else $error("index port read lost the index");

  AST_OUT_RESET: assert property (
    !$past(rst_b_i)
    |-> (!hsync_o && !blank_o && !display_en_o))
    else $error("raster outputs not idle after reset");

  AST_FRAME_STEP: assert property (
    (tick && line_end && st_reg.vcnt != vt11)
    |=> (st_reg.vcnt == $past(st_reg.vcnt) + 11'h001))
    else $error("line counter did not step at line end");

  AST_BLANK_HOLD: assert property (
    !tick
    |=> $stable(st_reg.blank))
    else $error("blank changed between character ticks");

  AST_SYNC_HOLD: assert property (
    !tick
    |=> $stable(st_reg.hs_raw))
    else $error("sync changed between character ticks");

  // Stretch must end exactly when its dot count runs out
  AST_STRETCH_END: assert property (
    (st_reg.stretch_cnt == 6'h01 && !st_reg.hs_skewed_prev && !hs_after_skew)
    |=> !hsync_o)
    else $error("sync stretched beyond its extra dots");

  COV_WORD_WRITE: cover property (io_wr_i && acc_idx && io_be_i == 2'h3);
  COV_FRAME_WRAP: cover property (tick && line_end && st_reg.vcnt == vt11);
  COV_STRETCH: cover property (st_reg.stretch_cnt == `CRT_STRETCH_DOTS);
  COV_SKEW3: cover property (hs_sk.sel == 2'h3 && $rose(hsync_o));
  COV_DE_SKEW3: cover property (de_sk.sel == 2'h3 && $fell(display_en_o));
endmodule

// *** bench/crt_monitor.sv ***
`timescale 1ns/1ps
// ============================================================
// Display-side monitor: times the raster edges like a CRT would
module crt_monitor (
  input wire logic clk_i,
  input wire logic hsync_i,
  input wire logic blank_i,
  input wire logic de_i,
  output int period_o,
  output int sync_w_o,
  output int blank_w_o,
  output int de_w_o,
  output int hs_ofs_o,
  output int de_ofs_o
);
  int t = 0;
  int hs_r = 0;
  int b_r = 0;
  int de_r = 0;
  int de_f = 0;
  logic hs_q = 1'b0;
  logic b_q = 1'b0;
  logic de_q = 1'b0;

  // Edge stamps in clocks; values only settle after a few full lines
  always @(posedge clk_i) begin
    t <= t + 1;
    hs_q <= hsync_i;
    b_q <= blank_i;
    de_q <= de_i;
    if (hsync_i && !hs_q) begin
      period_o <= t - hs_r;
      hs_r <= t;
      hs_ofs_o <= t - b_r;
    end
    if (!hsync_i && hs_q) sync_w_o <= t - hs_r;
    if (blank_i && !b_q) begin
      b_r <= t;
      de_ofs_o <= t - de_f;
    end
    if (!blank_i && b_q) blank_w_o <= t - b_r;
    if (de_i && !de_q) de_r <= t;
    if (!de_i && de_q) begin
      de_w_o <= t - de_r;
      de_f <= t;
    end
  end
endmodule

// *** bench/crt_raster_timing_regs_test.sv ***
`timescale 1ns/1ps
`include "crt_defines.svh"
`define CHK(nm, exp, got) begin compares++; if ((got) !== (exp)) begin fails++; \
  $display("[ERR] %s exp %0h got %0h", nm, exp, got); end end

module crt_raster_timing_regs_test;
  import crt_pkg::*;
  localparam int DPC = 2;
  typedef struct packed {logic rd; logic [15:0] data;} crt_note_t;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic color_sel_i = 1'b1;
  logic [15:0] io_addr_i = 16'h0000;
  logic io_wr_i = 1'b0;
  logic io_rd_i = 1'b0;
  logic [1:0] io_be_i = 2'h0;
  logic [15:0] io_wdata_i = 16'h0000;
  logic [15:0] io_rdata_o;
  logic io_hit_o;
  logic hsync_o;
  logic blank_o;
  logic display_en_o;
  crt_note_t notes[$];
  crt_note_t nt;
  int fails = 0;
  int compares = 0;
  logic [31:0] seed = 32'h0d49edeb;
  int period, sync_w, blank_w, de_w, hs_ofs, de_ofs, de_ofs0;
  logic [7:0] idx;
  logic [7:0] d;
  logic [15:0] base;
  logic [15:0] other;
  logic [15:0] w [10];
  logic [1:0] skd [3] = '{2'h0, 2'h3, 2'h1};
  logic [1:0] skh [3] = '{2'h0, 2'h3, 2'h2};
  logic str [3] = '{1'b0, 1'b0, 1'b1};

  // ============================================================
  // Clock, design and display monitor
  always #2 clk_i = ~clk_i;

  crt_timing #(.DOTS_PER_CHAR(DPC)) i_dut (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .color_sel_i(color_sel_i),
    .io_addr_i(io_addr_i), .io_wr_i(io_wr_i), .io_rd_i(io_rd_i),
    .io_be_i(io_be_i), .io_wdata_i(io_wdata_i), .io_rdata_o(io_rdata_o),
    .io_hit_o(io_hit_o), .hsync_o(hsync_o), .blank_o(blank_o),
    .display_en_o(display_en_o)
  );

  crt_monitor i_mon (
    .clk_i(clk_i), .hsync_i(hsync_o), .blank_i(blank_o), .de_i(display_en_o),
    .period_o(period), .sync_w_o(sync_w), .blank_w_o(blank_w), .de_w_o(de_w),
    .hs_ofs_o(hs_ofs), .de_ofs_o(de_ofs)
  );

  // ============================================================
  // Helpers
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  // One strobe cycle, then an idle cycle so strobes never collide
  task automatic io_acc(input logic rd, input logic [15:0] a, input logic [1:0] be,
                        input logic [15:0] wd, input logic note, input logic [15:0] exp);
    @(posedge clk_i);
    #1;
    io_rd_i = rd;
    io_wr_i = !rd;
    io_addr_i = a;
    io_be_i = be;
    io_wdata_i = wd;
    if (note) notes.push_back('{rd, exp});
    @(posedge clk_i);
    #1;
    io_rd_i = 1'b0;
    io_wr_i = 1'b0;
  endtask

  task automatic stop_test();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // ============================================================
  // Scoreboard: each hit consumes the oldest note
  always @(negedge clk_i) begin
    if (io_hit_o === 1'b1) begin
      if (notes.size() == 0) begin
        `CHK("stray hit", 1'b0, 1'b1)
      end else begin
        nt = notes.pop_front();
        if (nt.rd) `CHK("rdata", nt.data, io_rdata_o)
      end
    end
  end

  // Watchdog well beyond the expected run of about 30 us
  initial begin
    #100000;
    fails++;
    stop_test();
  end

  // ============================================================
  // Main sequence
  initial begin
    repeat (16) @(posedge clk_i);
    #1;
    rst_b_i = 1'b1;
    `CHK("hsync rst", 1'b0, hsync_o)
    `CHK("blank rst", 1'b0, blank_o)
    io_acc(1, `CRT_IO_COLOR, 2'b01, 16'h0, 1, 16'h0000);
    // Every register, ranges alternating between mono and color; foreign range must be ignored
    for (int i = 0; i < 10; i++) begin
      idx = (i < 8) ? i[7:0] : ((i == 8) ? `CRT_IDX_HEXT : `CRT_IDX_VEXT);
      color_sel_i = i[0];
      base = i[0] ? `CRT_IO_COLOR : `CRT_IO_MONO;
      other = i[0] ? `CRT_IO_MONO : `CRT_IO_COLOR;
      seed = xorshift(seed);
      d = (idx == `CRT_IDX_HBEND) ? {1'b0, seed[6:0]} : seed[7:0];
      io_acc(0, base, 2'b01, {8'h00, idx}, 1, 16'h0);
      io_acc(0, base + `CRT_IO_DATA_OFS, 2'b01, {seed[15:8], d}, 1, 16'h0);
      io_acc(0, other + `CRT_IO_DATA_OFS, 2'b01, {8'h00, ~d}, 0, 16'h0);
      io_acc(1, base + `CRT_IO_DATA_OFS, 2'b01, 16'h0, 1, {8'h00, d});
      io_acc(1, base, 2'b01, 16'h0, 1, {d, idx});
    end
    // Unmapped index drops writes and reads zero
    io_acc(0, base, 2'b01, 16'h0008, 1, 16'h0);
    io_acc(0, base + `CRT_IO_DATA_OFS, 2'b01, 16'h005a, 1, 16'h0);
    io_acc(1, base + `CRT_IO_DATA_OFS, 2'b01, 16'h0, 1, 16'h0000);
    // Word write, then high lane only at the index port
    io_acc(0, base, 2'b11, {8'h3c, `CRT_IDX_VTOTAL}, 1, 16'h0);
    io_acc(1, base + `CRT_IO_DATA_OFS, 2'b01, 16'h0, 1, 16'h003c);
    io_acc(0, base, 2'b10, 16'hc300, 1, 16'h0);
    io_acc(1, base, 2'b01, 16'h0, 1, {8'hc3, `CRT_IDX_VTOTAL});
    // Second reset mid-run: registers, index and counters start over
    rst_b_i = 1'b0;
    repeat (4) @(posedge clk_i);
    #1;
    rst_b_i = 1'b1;
    io_acc(1, `CRT_IO_COLOR, 2'b01, 16'h0, 1, 16'h0000);
    // Raster: total 0x104, de end 0xa0, blank 0xc0..0xf0, sync 0x100..0x106, 3-line frame
    for (int k = 0; k < 3; k++) begin
      w = '{16'h0400, 16'ha001, 16'hc002, {1'b0, skd[k], 5'h10, 8'h03}, 16'h0004,
            {1'b1, skh[k], 5'h06, 8'h05}, {1'b0, str[k], 6'h19, 8'h5d},
            16'h0206, 16'h0007, 16'h005e};
      for (int j = 0; j < 10; j++) io_acc(0, `CRT_IO_COLOR, 2'b11, w[j], 1, 16'h0);
      repeat (4 * 265 * DPC) @(posedge clk_i);
      #1;
      `CHK("line period", (9'h104 + 5) * DPC, period)
      `CHK("de width", (8'ha0 + 1) * DPC, de_w)
      `CHK("blank width", 8'h30 * DPC, blank_w)
      `CHK("sync width", 6 * DPC + 32 * str[k], sync_w)
      `CHK("sync offset", (8'h40 + skh[k]) * DPC, hs_ofs)
      if (k == 0) de_ofs0 = de_ofs;
      `CHK("de skew", skd[k] * DPC, de_ofs0 - de_ofs)
    end
    repeat (4) @(posedge clk_i);
    `CHK("notes left", 0, notes.size())
    stop_test();
  end
endmodule
